// ---- rtl/bti_ctrl.sv ----
// Burst time insertion control: register file and insertion control logic.
// Assumes a classic Wishbone master and video timing strobes on CLK_I.
//
// Functional notes
// - One on/off bit includes or suppresses the 10-field colour sequence.
// - Time reference is inserted only while its enable bit is on.
// - Tracking select: no tracking, track by offset, or track by time.
// - Read-only register shows the signed seconds offset currently applied.
// - Separately written signed pending offset waits for a trigger.
// - Trigger time of day held as hours, minutes and seconds.
// - Trigger date held as year, month and day.
// - Delayed trigger applies pending offset when date and time are reached.
// - Level trigger applies pending offset while on; off keeps current offset.
// - Output delayed by 27 MHz periods, clipped to 0..63519, default 0.
// - Output phased by whole lines, clipped to 0..524, default 0.
// - Output offset by whole frames, clipped to 0..29, default 0.
// - Interval timecode inserted only while its enable bit is on.
// - First timecode line selectable 10..20, clipped, default 14.
// - Second timecode line independently selectable 10..20, default 14.
// - Panel actions go only to the selected one of two timecode outputs.
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module bti_ctrl (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic FRAME_START_I,
  input wire logic LINE_START_I,
  input wire logic REF_TICK_I,
  input wire logic [15:0] NOW_YEAR_I,
  input wire logic [3:0] NOW_MONTH_I,
  input wire logic [4:0] NOW_DAY_I,
  input wire logic [4:0] NOW_HOUR_I,
  input wire logic [5:0] NOW_MIN_I,
  input wire logic [5:0] NOW_SEC_I,
  input wire logic PANEL_ACT_I,
  output logic FIELD_SEQ_EN_O,
  output logic TR_ENABLE_O,
  output logic [1:0] TR_TRACK_O,
  output logic [24:0] TR_OFFSET_O,
  output logic TR_INSERT_O,
  output logic ITC_ENABLE_O,
  output logic [4:0] ITC_LINE1_O,
  output logic [4:0] ITC_LINE2_O,
  output logic PANEL_LTC1_ACT_O,
  output logic PANEL_LTC2_ACT_O
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic fseq;
    logic tr_en;
    logic [1:0] track;
    logic dly;
    logic lvl;
    logic itc_en;
    logic panel_sel;
    logic [24:0] pend;
    logic [24:0] applied;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
    logic [15:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [15:0] clk_ph;
    logic [9:0] line_ph;
    logic [4:0] frm_ph;
    logic [4:0] itc1;
    logic [4:0] itc2;
    logic apply_req;
    logic rearm;
    logic insert;
    logic ltc1;
    logic ltc2;
  } bti_regs_t;

  localparam bti_regs_t REGS_RESET = '{
    ack: 1'b0,
    rdat: 32'h0000_0000,
    fseq: 1'b0,
    tr_en: 1'b0,
    track: bti_pkg::TRACK_NONE,
    dly: 1'b0,
    lvl: 1'b0,
    itc_en: 1'b0,
    panel_sel: 1'b0,
    pend: bti_pkg::OFFSET_RESET,
    applied: bti_pkg::OFFSET_RESET,
    hour: 5'h00,
    min: 6'h00,
    sec: 6'h00,
    year: 16'h0000,
    month: 4'h0,
    day: 5'h00,
    clk_ph: bti_pkg::CLOCK_PHASE_RESET,
    line_ph: bti_pkg::LINE_PHASE_RESET,
    frm_ph: bti_pkg::FRAME_PHASE_RESET,
    itc1: bti_pkg::ITC_LINE_RESET,
    itc2: bti_pkg::ITC_LINE_RESET,
    apply_req: 1'b0,
    rearm: 1'b0,
    insert: 1'b0,
    ltc1: 1'b0,
    ltc2: 1'b0
  };

  bti_regs_t regs_ff;
  bti_regs_t nxt_regs;

  logic trig_fire;
  logic ph_busy;
  logic ph_done;
  logic [41:0] now_stamp;
  logic [41:0] at_stamp;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] clip_u(input logic [31:0] v, input logic [31:0] lo,
                                         input logic [31:0] hi);
    logic [31:0] res;
    res = v;
    if (v < lo) begin
      res = lo;
    end else if (v > hi) begin
      res = hi;
    end
    return res;
  endfunction

  function automatic logic [24:0] clip_s(input logic [31:0] v);
    logic [24:0] res;
    res = v[24:0];
    if ($signed(v) > $signed({{7{bti_pkg::OFFSET_MAX[24]}}, bti_pkg::OFFSET_MAX})) begin
      res = bti_pkg::OFFSET_MAX;
    end else if ($signed(v) < $signed({{7{bti_pkg::OFFSET_MIN[24]}}, bti_pkg::OFFSET_MIN})) begin
      res = bti_pkg::OFFSET_MIN;
    end
    return res;
  endfunction

  // ==========================================================================
  // Register read view
  function automatic logic [31:0] read_reg(input bti_regs_t r, input logic [7:0] adr,
                                           input logic busy);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (adr)
      bti_pkg::OFS_CTRL: begin
        v[bti_pkg::CTRL_FSEQ_BIT] = r.fseq;
        v[bti_pkg::CTRL_TREN_BIT] = r.tr_en;
        v[bti_pkg::CTRL_TRACK_LSB +: 2] = r.track;
        v[bti_pkg::CTRL_DLY_BIT] = r.dly;
        v[bti_pkg::CTRL_LVL_BIT] = r.lvl;
        v[bti_pkg::CTRL_ITC_BIT] = r.itc_en;
        v[bti_pkg::CTRL_PANEL_BIT] = r.panel_sel;
      end
      bti_pkg::OFS_PEND_OFFSET: v = {{7{r.pend[24]}}, r.pend};
      bti_pkg::OFS_APPLIED_OFFSET: v = {{7{r.applied[24]}}, r.applied};
      bti_pkg::OFS_TRIG_TIME: begin
        v[bti_pkg::TIM_HOUR_LSB +: 5] = r.hour;
        v[bti_pkg::TIM_MIN_LSB +: 6] = r.min;
        v[bti_pkg::TIM_SEC_LSB +: 6] = r.sec;
      end
      bti_pkg::OFS_TRIG_DATE: begin
        v[bti_pkg::DATE_YEAR_LSB +: 16] = r.year;
        v[bti_pkg::DATE_MONTH_LSB +: 4] = r.month;
        v[bti_pkg::DATE_DAY_LSB +: 5] = r.day;
      end
      bti_pkg::OFS_CLOCK_PHASE: v[15:0] = r.clk_ph;
      bti_pkg::OFS_LINE_PHASE: v[9:0] = r.line_ph;
      bti_pkg::OFS_FRAME_PHASE: v[4:0] = r.frm_ph;
      bti_pkg::OFS_ITC_LINES: begin
        v[bti_pkg::ITC_FIRST_LSB +: 5] = r.itc1;
        v[bti_pkg::ITC_SECOND_LSB +: 5] = r.itc2;
      end
      bti_pkg::OFS_STATUS: begin
        v[bti_pkg::STAT_APPLY_BIT] = r.apply_req;
        v[bti_pkg::STAT_PHASE_BIT] = busy;
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    logic [31:0] cur;
    logic [31:0] wv;
    logic [1:0] trk;
    logic access;
    logic wr;
    cur = read_reg(regs_ff, ADR_I, ph_busy);
    wv = merge(cur, DAT_I, SEL_I);
    trk = wv[bti_pkg::CTRL_TRACK_LSB +: 2];
    access = CYC_I && STB_I;
    // Write lands on the edge where the master sees ack
    wr = access && WE_I && regs_ff.ack;
    nxt_regs = regs_ff;
    nxt_regs.ack = access && !regs_ff.ack;
    nxt_regs.rdat = cur;
    nxt_regs.rearm = 1'b0;

    if (wr) begin
      unique case (ADR_I)
        bti_pkg::OFS_CTRL: begin
          nxt_regs.fseq = wv[bti_pkg::CTRL_FSEQ_BIT];
          nxt_regs.tr_en = wv[bti_pkg::CTRL_TREN_BIT];
          // Unused code 3 reads back as no tracking
          nxt_regs.track = (trk == 2'b11) ? bti_pkg::TRACK_NONE : trk;
          nxt_regs.dly = wv[bti_pkg::CTRL_DLY_BIT];
          nxt_regs.lvl = wv[bti_pkg::CTRL_LVL_BIT];
          nxt_regs.itc_en = wv[bti_pkg::CTRL_ITC_BIT];
          nxt_regs.panel_sel = wv[bti_pkg::CTRL_PANEL_BIT];
        end
        bti_pkg::OFS_PEND_OFFSET: nxt_regs.pend = clip_s(wv);
        bti_pkg::OFS_TRIG_TIME: begin
          nxt_regs.hour = wv[bti_pkg::TIM_HOUR_LSB +: 5];
          nxt_regs.min = wv[bti_pkg::TIM_MIN_LSB +: 6];
          nxt_regs.sec = wv[bti_pkg::TIM_SEC_LSB +: 6];
          nxt_regs.rearm = 1'b1;
        end
        bti_pkg::OFS_TRIG_DATE: begin
          nxt_regs.year = wv[bti_pkg::DATE_YEAR_LSB +: 16];
          nxt_regs.month = wv[bti_pkg::DATE_MONTH_LSB +: 4];
          nxt_regs.day = wv[bti_pkg::DATE_DAY_LSB +: 5];
          nxt_regs.rearm = 1'b1;
        end
        bti_pkg::OFS_CLOCK_PHASE: begin
          nxt_regs.clk_ph = 16'(clip_u(wv, 32'h0,
                                {16'h0, bti_pkg::CLOCK_PHASE_MAX}));
        end
        bti_pkg::OFS_LINE_PHASE: begin
          nxt_regs.line_ph = 10'(clip_u(wv, 32'h0,
                                 {22'h0, bti_pkg::LINE_PHASE_MAX}));
        end
        bti_pkg::OFS_FRAME_PHASE: begin
          nxt_regs.frm_ph = 5'(clip_u(wv, 32'h0,
                               {27'h0, bti_pkg::FRAME_PHASE_MAX}));
        end
        bti_pkg::OFS_ITC_LINES: begin
          nxt_regs.itc1 = 5'(clip_u({24'h0, wv[bti_pkg::ITC_FIRST_LSB +: 8]},
                                 {27'h0, bti_pkg::ITC_LINE_MIN},
                                 {27'h0, bti_pkg::ITC_LINE_MAX}));
          nxt_regs.itc2 = 5'(clip_u({24'h0, wv[bti_pkg::ITC_SECOND_LSB +: 8]},
                                 {27'h0, bti_pkg::ITC_LINE_MIN},
                                 {27'h0, bti_pkg::ITC_LINE_MAX}));
        end
        default: begin
        end
      endcase
    end

    // Offset update only on a frame start, so no frame mixes old and new time
    if (FRAME_START_I && (regs_ff.apply_req || regs_ff.lvl)) begin
      nxt_regs.applied = regs_ff.pend;
    end
    // A trigger in the same cycle as the frame start survives the clear
    if (FRAME_START_I) begin
      nxt_regs.apply_req = 1'b0;
    end
    if (trig_fire) begin
      nxt_regs.apply_req = 1'b1;
    end

    // Without tracking the reference sits at the frame start, unphased
    if (regs_ff.track == bti_pkg::TRACK_NONE) begin
      nxt_regs.insert = regs_ff.tr_en && FRAME_START_I;
    end else begin
      nxt_regs.insert = regs_ff.tr_en && ph_done;
    end

    nxt_regs.ltc1 = PANEL_ACT_I && !regs_ff.panel_sel;
    nxt_regs.ltc2 = PANEL_ACT_I && regs_ff.panel_sel;
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      regs_ff <= REGS_RESET;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // ==========================================================================
  // Trigger and phasing engines
  assign now_stamp = {NOW_YEAR_I, NOW_MONTH_I, NOW_DAY_I, NOW_HOUR_I, NOW_MIN_I, NOW_SEC_I};
  assign at_stamp = {regs_ff.year, regs_ff.month, regs_ff.day,
                     regs_ff.hour, regs_ff.min, regs_ff.sec};

  bti_trig #(
    .STAMP_W(42)
  ) u_trig (
    .clk_i(CLK_I),
    .rst_i(RESET_I),
    .arm_i(regs_ff.dly),
    .rearm_i(regs_ff.rearm),
    .now_i(now_stamp),
    .at_i(at_stamp),
    .fire_o(trig_fire)
  );

  // Phasing beyond one frame lets insertion occur only every few frames
  bti_phase u_phase (
    .clk_i(CLK_I),
    .rst_i(RESET_I),
    .frame_i(FRAME_START_I),
    .line_i(LINE_START_I),
    .tick_i(REF_TICK_I),
    .frames_i(regs_ff.frm_ph),
    .lines_i(regs_ff.line_ph),
    .clocks_i(regs_ff.clk_ph),
    .busy_o(ph_busy),
    .done_o(ph_done)
  );

  // ==========================================================================
  // Outputs
  assign DAT_O = regs_ff.rdat;
  assign ACK_O = regs_ff.ack;
  assign FIELD_SEQ_EN_O = regs_ff.fseq;
  assign TR_ENABLE_O = regs_ff.tr_en;
  assign TR_TRACK_O = regs_ff.track;
  assign TR_OFFSET_O = regs_ff.applied;
  assign TR_INSERT_O = regs_ff.insert;
  assign ITC_ENABLE_O = regs_ff.itc_en;
  assign ITC_LINE1_O = regs_ff.itc1;
  assign ITC_LINE2_O = regs_ff.itc2;
  assign PANEL_LTC1_ACT_O = regs_ff.ltc1;
  assign PANEL_LTC2_ACT_O = regs_ff.ltc2;
endmodule
`default_nettype wire

// ---- inc/bti_pkg.sv ----
// Constants shared by the burst time insertion control block.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package bti_pkg;
  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PEND_OFFSET = 8'h04;
  localparam logic [7:0] OFS_APPLIED_OFFSET = 8'h08;
  localparam logic [7:0] OFS_TRIG_TIME = 8'h0C;
  localparam logic [7:0] OFS_TRIG_DATE = 8'h10;
  localparam logic [7:0] OFS_CLOCK_PHASE = 8'h14;
  localparam logic [7:0] OFS_LINE_PHASE = 8'h18;
  localparam logic [7:0] OFS_FRAME_PHASE = 8'h1C;
  localparam logic [7:0] OFS_ITC_LINES = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;

  // ==========================================================================
  // Field positions
  localparam int CTRL_FSEQ_BIT = 0;
  localparam int CTRL_TREN_BIT = 1;
  localparam int CTRL_TRACK_LSB = 2;
  localparam int CTRL_DLY_BIT = 4;
  localparam int CTRL_LVL_BIT = 5;
  localparam int CTRL_ITC_BIT = 6;
  localparam int CTRL_PANEL_BIT = 7;
  localparam int TIM_SEC_LSB = 0;
  localparam int TIM_MIN_LSB = 8;
  localparam int TIM_HOUR_LSB = 16;
  localparam int DATE_DAY_LSB = 0;
  localparam int DATE_MONTH_LSB = 8;
  localparam int DATE_YEAR_LSB = 16;
  localparam int ITC_FIRST_LSB = 0;
  localparam int ITC_SECOND_LSB = 8;
  localparam int STAT_APPLY_BIT = 0;
  localparam int STAT_PHASE_BIT = 1;

  // ==========================================================================
  // Limits and reset values
  localparam logic [24:0] OFFSET_MAX = 25'h098967F;
  localparam logic [24:0] OFFSET_MIN = 25'h1676981;
  localparam logic [24:0] OFFSET_RESET = 25'h0000000;
  localparam logic [15:0] CLOCK_PHASE_MAX = 16'hF81F;
  localparam logic [15:0] CLOCK_PHASE_RESET = 16'h0000;
  localparam logic [9:0] LINE_PHASE_MAX = 10'h20C;
  localparam logic [9:0] LINE_PHASE_RESET = 10'h000;
  localparam logic [4:0] FRAME_PHASE_MAX = 5'h1D;
  localparam logic [4:0] FRAME_PHASE_RESET = 5'h00;
  localparam logic [4:0] ITC_LINE_MIN = 5'h0A;
  localparam logic [4:0] ITC_LINE_MAX = 5'h14;
  localparam logic [4:0] ITC_LINE_RESET = 5'h0E;

  // ==========================================================================
  // Tracking modes
  typedef enum logic [1:0] {
    TRACK_NONE = 2'b00,
    TRACK_BY_OFFSET = 2'b01,
    TRACK_BY_TIME = 2'b10
  } bti_track_t;
endpackage

// ---- rtl/bti_trig.sv ----
// Date and time trigger: one pulse when the current stamp reaches the target.
// Assumes both stamps come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module bti_trig #(
  parameter int STAMP_W = 42
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic arm_i,
  input wire logic rearm_i,
  input wire logic [STAMP_W-1:0] now_i,
  input wire logic [STAMP_W-1:0] at_i,
  output logic fire_o
);
  typedef struct packed {
    logic fired;
    logic fire;
  } bti_trig_st_t;

  bti_trig_st_t st_ff;
  bti_trig_st_t nxt_st;

  // ==========================================================================
  // Greater-or-equal compare so a stamp that skips the exact second still fires
  always_comb begin
    nxt_st = st_ff;
    nxt_st.fire = arm_i && !st_ff.fired && !rearm_i && (now_i >= at_i);
    if (!arm_i || rearm_i) begin
      nxt_st.fired = 1'b0;
    end else if (nxt_st.fire) begin
      nxt_st.fired = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign fire_o = st_ff.fire;
endmodule
`default_nettype wire

// ---- rtl/bti_phase.sv ----
// Phasing delay: frames, then lines, then reference clock ticks after a frame start.
// Assumes frame, line and tick strobes are one-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
module bti_phase (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic frame_i,
  input wire logic line_i,
  input wire logic tick_i,
  input wire logic [4:0] frames_i,
  input wire logic [9:0] lines_i,
  input wire logic [15:0] clocks_i,
  output logic busy_o,
  output logic done_o
);
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_FRAMES = 2'b01,
    PH_LINES = 2'b10,
    PH_CLOCKS = 2'b11
  } bti_ph_state_t;

  typedef struct packed {
    bti_ph_state_t state;
    logic [15:0] cnt;
    logic done;
  } bti_ph_st_t;

  bti_ph_st_t st_ff;
  bti_ph_st_t nxt_st;

  // ==========================================================================
  // One delay in flight; frame starts seen while busy count frames down in PH_FRAMES and are ignored in PH_LINES and PH_CLOCKS
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    unique case (st_ff.state)
      PH_IDLE: begin
        if (frame_i) begin
          nxt_st.state = PH_FRAMES;
          nxt_st.cnt = {11'h000, frames_i};
        end
      end
      PH_FRAMES: begin
        if (st_ff.cnt == 16'h0000) begin
          nxt_st.state = PH_LINES;
          nxt_st.cnt = {6'h00, lines_i};
        end else if (frame_i) begin
          nxt_st.cnt = st_ff.cnt - 16'h0001;
        end
      end
      PH_LINES: begin
        if (st_ff.cnt == 16'h0000) begin
          nxt_st.state = PH_CLOCKS;
          nxt_st.cnt = clocks_i;
        end else if (line_i) begin
          nxt_st.cnt = st_ff.cnt - 16'h0001;
        end
      end
      PH_CLOCKS: begin
        if (st_ff.cnt == 16'h0000) begin
          nxt_st.state = PH_IDLE;
          nxt_st.done = 1'b1;
        end else if (tick_i) begin
          nxt_st.cnt = st_ff.cnt - 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '{state: PH_IDLE, cnt: 16'h0000, done: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy_o = (st_ff.state != PH_IDLE);
  assign done_o = st_ff.done;
endmodule
`default_nettype wire

// ---- verif/bti_vid_model.sv ----
// Video timing stand-in: frame, line and reference tick strobes.
// Assumes the block's clock and reset; short periods keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module bti_vid_model #(
  parameter int TICK_DIV = 4,
  parameter int LINE_DIV = 16,
  parameter int FRAME_DIV = 160
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic frame_o,
  output logic line_o,
  output logic tick_o
);
  int cnt;
  // Frame start coincides with a line start and a tick, as on real video
  always_ff @(posedge clk_i) begin
    cnt <= (rst_i || cnt == FRAME_DIV - 1) ? 0 : cnt + 1;
    frame_o <= !rst_i && cnt == FRAME_DIV - 1;
    line_o <= !rst_i && cnt % LINE_DIV == LINE_DIV - 1;
    tick_o <= !rst_i && cnt % TICK_DIV == TICK_DIV - 1;
  end
endmodule
`default_nettype wire

// ---- verif/bti_ctrl_checker.sv ----
// Concurrent checks on the ports of the insertion control block.
// Assumes one clock domain and the synchronous reset of the block.
`timescale 1ns/1ps
`default_nettype none
module bti_ctrl_checker (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic ACK_O,
  input wire logic FRAME_START_I,
  input wire logic PANEL_ACT_I,
  input wire logic FIELD_SEQ_EN_O,
  input wire logic TR_ENABLE_O,
  input wire logic [1:0] TR_TRACK_O,
  input wire logic [24:0] TR_OFFSET_O,
  input wire logic TR_INSERT_O,
  input wire logic ITC_ENABLE_O,
  input wire logic [4:0] ITC_LINE1_O,
  input wire logic [4:0] ITC_LINE2_O,
  input wire logic PANEL_LTC1_ACT_O,
  input wire logic PANEL_LTC2_ACT_O
);
  // ==========================================================================
  // Bus and insertion properties
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  a_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("request not answered in one cycle");
  a_ack_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack held longer than one cycle");
  a_fseq_write: assert property (
    ACK_O && WE_I && ADR_I == bti_pkg::OFS_CTRL && SEL_I[0]
    |=> FIELD_SEQ_EN_O == $past(DAT_I[0]))
    else $error("field sequence enable not taken from write");
  a_itc_write: assert property (
    ACK_O && WE_I && ADR_I == bti_pkg::OFS_CTRL && SEL_I[0]
    |=> ITC_ENABLE_O == $past(DAT_I[6]))
    else $error("interval timecode enable not taken from write");
  a_insert_gate: assert property (
    TR_INSERT_O |-> TR_ENABLE_O || $past(TR_ENABLE_O))
    else $error("time reference inserted while disabled");
  a_insert_none: assert property (
    FRAME_START_I && TR_TRACK_O == 2'h0 && TR_ENABLE_O |=> TR_INSERT_O)
    else $error("unphased insert missing after frame start");
  a_offset_frame: assert property (
    $changed(TR_OFFSET_O) |-> $past(FRAME_START_I) || $past(FRAME_START_I, 2))
    else $error("applied offset changed away from a frame start");
  a_line1_range: assert property (
    ITC_LINE1_O >= bti_pkg::ITC_LINE_MIN && ITC_LINE1_O <= bti_pkg::ITC_LINE_MAX)
    else $error("first timecode line out of range");
  a_line2_range: assert property (
    ITC_LINE2_O >= bti_pkg::ITC_LINE_MIN && ITC_LINE2_O <= bti_pkg::ITC_LINE_MAX)
    else $error("second timecode line out of range");
  a_panel_route: assert property (
    PANEL_LTC1_ACT_O || PANEL_LTC2_ACT_O
    |-> $past(PANEL_ACT_I) && !(PANEL_LTC1_ACT_O && PANEL_LTC2_ACT_O))
    else $error("panel action routed to wrong or both outputs");
endmodule
bind bti_ctrl bti_ctrl_checker bti_ctrl_checker_inst (.*);
`default_nettype wire

// ---- verif/bti_ctrl_tb.sv ----
// Self-checking bench for the burst time insertion control block.
// Assumes the video timing stand-in drives frame, line and tick strobes.
`timescale 1ns/1ps
`default_nettype none
module bti_ctrl_tb;
  logic clk, rst, cyc, stb, we, panel, ack, fs, ls, tk, fseq, tren, ins, itc, l1a, l2a;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, dat_o, rdat;
  logic [5:0] sec;
  logic [1:0] trk;
  logic [24:0] tro;
  logic [4:0] l1, l2;
  int errors, n_checks;
  bti_vid_model bti_vid_model_inst (.clk_i(clk), .rst_i(rst), .frame_o(fs), .line_o(ls),
    .tick_o(tk));
  bti_ctrl bti_ctrl_inst (.CLK_I(clk), .RESET_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .FRAME_START_I(fs),
    .LINE_START_I(ls), .REF_TICK_I(tk), .NOW_YEAR_I(16'h07E8), .NOW_MONTH_I(4'h1),
    .NOW_DAY_I(5'h01), .NOW_HOUR_I(5'h0C), .NOW_MIN_I(6'h00), .NOW_SEC_I(sec),
    .PANEL_ACT_I(panel), .FIELD_SEQ_EN_O(fseq), .TR_ENABLE_O(tren), .TR_TRACK_O(trk),
    .TR_OFFSET_O(tro), .TR_INSERT_O(ins), .ITC_ENABLE_O(itc), .ITC_LINE1_O(l1),
    .ITC_LINE2_O(l2), .PANEL_LTC1_ACT_O(l1a), .PANEL_LTC2_ACT_O(l2a));
  // ==========================================================================
  // Shared tasks
  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // Classic cycle: request held until ack is sampled, then released
  task automatic wb(input bit w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1);
    chk(k == 2, "ack latency");
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    wb(1'b0, a, 32'h0);
    chk(rdat === e, m);
  endtask
  task automatic clip(input logic [7:0] a, input logic [31:0] w, input logic [31:0] e);
    wb(1'b1, a, w);
    rd(a, e, "stored value not clipped");
  endtask
  // Waits for n frame starts, then lets a late update land
  task automatic wf(input int n);
    repeat (n) begin
      do @(posedge clk); while (fs !== 1'b1);
    end
    repeat (3) @(posedge clk);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_defaults;
    rd(bti_pkg::OFS_CTRL, 32'h0, "control reset");
    rd(bti_pkg::OFS_CLOCK_PHASE, 32'h0, "clock phase reset");
    rd(bti_pkg::OFS_LINE_PHASE, 32'h0, "line phase reset");
    rd(bti_pkg::OFS_FRAME_PHASE, 32'h0, "frame phase reset");
    rd(bti_pkg::OFS_ITC_LINES, 32'h0000_0E0E, "timecode lines reset");
    rd(8'h28, 32'h0, "unmapped read");
    chk(l1 === 5'h0E && l2 === 5'h0E, "timecode line ports");
  endtask
  task automatic t_ctrl;
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, bti_pkg::OFS_CTRL, (32'(m) << 2) | 32'h41);
      @(posedge clk);
      chk(trk === ((m == 3) ? 2'h0 : 2'(m)), "track mode");
      chk(fseq === 1'b1 && itc === 1'b1, "enables on");
    end
    wb(1'b1, bti_pkg::OFS_CTRL, 32'h0);
    @(posedge clk);
    chk(fseq === 1'b0 && itc === 1'b0 && tren === 1'b0, "enables off");
  endtask
  task automatic t_clip;
    clip(bti_pkg::OFS_CLOCK_PHASE, 32'h0000_FFFF, 32'h0000_F81F);
    clip(bti_pkg::OFS_LINE_PHASE, 32'h0000_03FF, 32'h0000_020C);
    clip(bti_pkg::OFS_FRAME_PHASE, 32'h0000_001F, 32'h0000_001D);
    clip(bti_pkg::OFS_ITC_LINES, 32'h0000_1F05, 32'h0000_140A);
    clip(bti_pkg::OFS_PEND_OFFSET, 32'h00FF_FFFF, 32'h0098_967F);
    clip(bti_pkg::OFS_APPLIED_OFFSET, 32'h0000_0005, 32'h0);
    chk(l1 === 5'h0A && l2 === 5'h14, "timecode line ports clipped");
    // Phaser latches the frame count at a frame start and the others as each phase ends; clear them before the first one
    wb(1'b1, bti_pkg::OFS_CLOCK_PHASE, 32'h0);
    wb(1'b1, bti_pkg::OFS_LINE_PHASE, 32'h0);
    wb(1'b1, bti_pkg::OFS_FRAME_PHASE, 32'h0);
  endtask
  task automatic t_insert;
    int d;
    int n;
    wb(1'b1, bti_pkg::OFS_CTRL, 32'h0);
    n = 0;
    repeat (400) begin
      @(posedge clk);
      if (ins === 1'b1) n++;
    end
    chk(n == 0, "insert while disabled");
    wb(1'b1, bti_pkg::OFS_CTRL, 32'h2);
    do @(posedge clk); while (fs !== 1'b1);
    @(posedge clk);
    chk(ins === 1'b1, "unphased insert");
    wb(1'b1, bti_pkg::OFS_FRAME_PHASE, 32'h1);
    wb(1'b1, bti_pkg::OFS_LINE_PHASE, 32'h2);
    wb(1'b1, bti_pkg::OFS_CLOCK_PHASE, 32'h3);
    wb(1'b1, bti_pkg::OFS_CTRL, 32'h6);
    do @(posedge clk); while (fs !== 1'b1);
    d = 0;
    do begin
      @(posedge clk);
      d++;
    end while (ins !== 1'b1 && d < 400);
    // One frame of 160, two lines of 16, three ticks of 4, small overhead
    chk(d >= 176 && d <= 224, "phased insert delay");
  endtask
  task automatic t_panel;
    for (int s = 0; s < 2; s++) begin
      wb(1'b1, bti_pkg::OFS_CTRL, 32'(s) << 7);
      panel <= 1'b1;
      @(posedge clk);
      panel <= 1'b0;
      @(posedge clk);
      chk(l1a === 1'(s == 0) && l2a === 1'(s == 1), "panel routing");
    end
  endtask
  task automatic t_level;
    wb(1'b1, bti_pkg::OFS_PEND_OFFSET, 32'hFFFF_FFFD);
    wb(1'b1, bti_pkg::OFS_CTRL, 32'h22);
    wf(1);
    chk(tro === 25'h1FF_FFFD, "level apply");
    rd(bti_pkg::OFS_APPLIED_OFFSET, 32'hFFFF_FFFD, "applied readback");
    wb(1'b1, bti_pkg::OFS_CTRL, 32'h2);
    wb(1'b1, bti_pkg::OFS_PEND_OFFSET, 32'h7);
    wf(2);
    chk(tro === 25'h1FF_FFFD, "offset not kept");
  endtask
  task automatic t_delay;
    wb(1'b1, bti_pkg::OFS_TRIG_TIME, 32'h000C_000C);
    wb(1'b1, bti_pkg::OFS_TRIG_DATE, 32'h07E8_0101);
    wb(1'b1, bti_pkg::OFS_PEND_OFFSET, 32'h9);
    wb(1'b1, bti_pkg::OFS_CTRL, 32'h12);
    wf(2);
    chk(tro === 25'h1FF_FFFD, "early timed apply");
    rd(bti_pkg::OFS_TRIG_TIME, 32'h000C_000C, "trigger time");
    rd(bti_pkg::OFS_TRIG_DATE, 32'h07E8_0101, "trigger date");
    sec <= 6'h0C;
    wf(2);
    chk(tro === 25'h000_0009, "timed apply missing");
  endtask
  // ==========================================================================
  // Run control
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {cyc, stb, we, panel} = 4'h0;
    adr = 8'h00;
    sel = 4'hF;
    dat = 32'h0;
    sec = 6'h0A;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_defaults;
    t_ctrl;
    t_clip;
    t_insert;
    t_panel;
    t_level;
    t_delay;
    final_report;
  end
  // Whole run is a few thousand cycles; this span is well beyond it
  initial begin
    #200us;
    errors++;
    final_report;
  end
endmodule
`default_nettype wire
